// >>> udt_pkg.sv
// Constants and types shared by the Ultra DMA timing configuration block.
package udt_pkg;

  // Configuration space map, byte addresses.
  localparam logic [7:0] UDT_DWORD_ADDR = 8'h48;
  localparam logic [7:0] UDT_ENABLE_OFS = 8'h48;
  localparam logic [7:0] UDT_TIMING_OFS = 8'h4A;

  // Byte lane positions of the two registers inside their dword.
  localparam int UDT_ENABLE_LANE = 0;
  localparam int UDT_TIMING_LO_LANE = 2;
  localparam int UDT_TIMING_HI_LANE = 3;

  // Reset values and writable bit masks.
  localparam logic [7:0] UDT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] UDT_ENABLE_MASK = 8'h0F;
  localparam logic [15:0] UDT_TIMING_RESET = 16'h0000;
  localparam logic [15:0] UDT_TIMING_MASK = 16'h3333;

  // Drive count and cycle field positions (low bit of each field).
  localparam int UDT_DRIVES = 4;
  localparam int UDT_FIELD_LSB [UDT_DRIVES] = '{0, 4, 8, 12};

  // Cycle field encodings.
  localparam logic [1:0] UDT_CODE_00 = 2'h0;
  localparam logic [1:0] UDT_CODE_01 = 2'h1;
  localparam logic [1:0] UDT_CODE_10 = 2'h2;

  // Write strobe period and ready-to-halt time, in base clocks.
  localparam logic [2:0] UDT_CT_4 = 3'h4;
  localparam logic [2:0] UDT_CT_3 = 3'h3;
  localparam logic [2:0] UDT_CT_2 = 3'h2;
  localparam logic [4:0] UDT_RP_33_00 = 5'h06;
  localparam logic [4:0] UDT_RP_33_01 = 5'h05;
  localparam logic [4:0] UDT_RP_33_10 = 5'h04;
  localparam logic [4:0] UDT_RP_66 = 5'h08;
  localparam logic [4:0] UDT_RP_133 = 5'h10;

  typedef logic [2:0] udt_period_t;
  typedef logic [4:0] udt_halt_t;

  typedef enum logic [1:0] {
    UDT_BASE_33,
    UDT_BASE_66,
    UDT_BASE_133
  } udt_base_e;

  // Whole state of the top module.
  typedef struct packed {
    logic [7:0] enable;
    logic [15:0] timing;
    logic [31:0] rdata;
    logic rvalid;
    logic [UDT_DRIVES-1:0] udma_en;
    logic [UDT_DRIVES-1:0][2:0] period;
    logic [UDT_DRIVES-1:0][4:0] halt;
    logic [UDT_DRIVES-1:0][1:0] base;
    logic [UDT_DRIVES-1:0] rsvd_code;
  } udt_state_s;

endpackage

// >>> udt_drive_if.sv
// Per-drive carrier between the register bank and the timing decoder.
`timescale 1ns/10ps
interface udt_drive_if;
  import udt_pkg::*;
  logic [1:0] cycle_field;
  logic base_clock_sel;
  logic fast_clock_sel;
  udt_base_e base;
  udt_period_t write_strobe_period;
  udt_halt_t ready_to_halt_time;
  logic reserved_code;

  modport decoder (
    input cycle_field,
    input base_clock_sel,
    input fast_clock_sel,
    output base,
    output write_strobe_period,
    output ready_to_halt_time,
    output reserved_code
  );

  modport bank (
    output cycle_field,
    output base_clock_sel,
    output fast_clock_sel,
    input base,
    input write_strobe_period,
    input ready_to_halt_time,
    input reserved_code
  );
endinterface

// >>> udt_drive_decode.sv
// Decodes one drive's cycle field against its selected base clock.
`timescale 1ns/10ps
module udt_drive_decode (
  // Drive settings and decoded timing.
  udt_drive_if.decoder drv
);
  import udt_pkg::*;

  always_comb begin
    drv.reserved_code = 1'b0;
    // The fast bit outranks the ordinary base clock select.
    if (drv.fast_clock_sel) begin
      drv.base = UDT_BASE_133;
    end else if (drv.base_clock_sel) begin
      drv.base = UDT_BASE_66;
    end else begin
      drv.base = UDT_BASE_33;
    end
    case (drv.base)
      UDT_BASE_133: begin
        drv.write_strobe_period = UDT_CT_3;
        drv.ready_to_halt_time = UDT_RP_133;
        // Reserved codes fall back to the only valid timing.
        drv.reserved_code = (drv.cycle_field != UDT_CODE_01);
      end
      UDT_BASE_66: begin
        drv.ready_to_halt_time = UDT_RP_66;
        if (drv.cycle_field == UDT_CODE_10) begin
          drv.write_strobe_period = UDT_CT_2;
        end else begin
          // Codes 00 and 11 take the slowest valid 66 MHz timing.
          drv.write_strobe_period = UDT_CT_3;
          drv.reserved_code = (drv.cycle_field != UDT_CODE_01);
        end
      end
      default: begin
        case (drv.cycle_field)
          UDT_CODE_01: begin
            drv.write_strobe_period = UDT_CT_3;
            drv.ready_to_halt_time = UDT_RP_33_01;
          end
          UDT_CODE_10: begin
            drv.write_strobe_period = UDT_CT_2;
            drv.ready_to_halt_time = UDT_RP_33_10;
          end
          default: begin
            // Code 11 runs as code 00, the slowest 33 MHz timing.
            drv.write_strobe_period = UDT_CT_4;
            drv.ready_to_halt_time = UDT_RP_33_00;
            drv.reserved_code = (drv.cycle_field != UDT_CODE_00);
          end
        endcase
      end
    endcase
  end

endmodule

// >>> udt_timing_config.sv
// Ultra DMA enable and cycle timing registers for four IDE drives.
`timescale 1ns/10ps
module udt_timing_config (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration space access, one dword per request.
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_byte_en,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Base clock selects held in a neighbouring register.
  input wire logic pri_drive0_base_clock_sel,
  input wire logic pri_drive1_base_clock_sel,
  input wire logic sec_drive0_base_clock_sel,
  input wire logic sec_drive1_base_clock_sel,
  input wire logic pri_drive0_fast_clock_sel,
  input wire logic pri_drive1_fast_clock_sel,
  input wire logic sec_drive0_fast_clock_sel,
  input wire logic sec_drive1_fast_clock_sel,
  // Per-drive settings for the Ultra DMA engines, index 0..3 = P0, P1, S0, S1.
  output logic [udt_pkg::UDT_DRIVES-1:0] udma_enable,
  output udt_pkg::udt_period_t [udt_pkg::UDT_DRIVES-1:0] write_strobe_period,
  output udt_pkg::udt_halt_t [udt_pkg::UDT_DRIVES-1:0] ready_to_halt_time,
  output logic [udt_pkg::UDT_DRIVES-1:0][1:0] base_clock_mode,
  output logic [udt_pkg::UDT_DRIVES-1:0] reserved_code
);
  import udt_pkg::*;

  udt_state_s state_q;
  udt_state_s state_d;
  logic [UDT_DRIVES-1:0] base_sel;
  logic [UDT_DRIVES-1:0] fast_sel;
  logic hit;

  udt_drive_if drive_if [UDT_DRIVES] ();

  assign base_sel = {sec_drive1_base_clock_sel, sec_drive0_base_clock_sel,
                     pri_drive1_base_clock_sel, pri_drive0_base_clock_sel};
  assign fast_sel = {sec_drive1_fast_clock_sel, sec_drive0_fast_clock_sel,
                     pri_drive1_fast_clock_sel, pri_drive0_fast_clock_sel};
  assign hit = (cfg_addr[7:2] == UDT_DWORD_ADDR[7:2]);

  // One decoder per drive; the field comes from the live register copy.
  for (genvar i = 0; i < UDT_DRIVES; i++) begin : g_drive
    assign drive_if[i].cycle_field = state_q.timing[UDT_FIELD_LSB[i] +: 2];
    assign drive_if[i].base_clock_sel = base_sel[i];
    assign drive_if[i].fast_clock_sel = fast_sel[i];
    udt_drive_decode u_decode (
      .drv(drive_if[i])
    );
  end

  // Decoder results gathered into plain vectors for the state update.
  logic [UDT_DRIVES-1:0][2:0] dec_period;
  logic [UDT_DRIVES-1:0][4:0] dec_halt;
  logic [UDT_DRIVES-1:0][1:0] dec_base;
  logic [UDT_DRIVES-1:0] dec_rsvd;

  for (genvar i = 0; i < UDT_DRIVES; i++) begin : g_collect
    assign dec_period[i] = drive_if[i].write_strobe_period;
    assign dec_halt[i] = drive_if[i].ready_to_halt_time;
    assign dec_base[i] = drive_if[i].base;
    assign dec_rsvd[i] = drive_if[i].reserved_code;
  end

  always_comb begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    // Writes land byte by byte; reserved bits are masked off.
    if (cfg_wr && hit) begin
      if (cfg_byte_en[UDT_ENABLE_LANE]) begin
        state_d.enable = cfg_wdata[7:0] & UDT_ENABLE_MASK;
      end
      if (cfg_byte_en[UDT_TIMING_LO_LANE]) begin
        state_d.timing[7:0] = cfg_wdata[23:16] & UDT_TIMING_MASK[7:0];
      end
      if (cfg_byte_en[UDT_TIMING_HI_LANE]) begin
        state_d.timing[15:8] = cfg_wdata[31:24] & UDT_TIMING_MASK[15:8];
      end
    end
    // Reads return the pre-write contents; unmapped dwords read as zero.
    if (cfg_rd) begin
      state_d.rvalid = 1'b1;
      state_d.rdata = hit ? {state_q.timing, 8'h00, state_q.enable} : 32'h0000_0000;
    end
    // Per-drive outputs follow the registers one cycle later.
    state_d.udma_en = state_q.enable[UDT_DRIVES-1:0];
    state_d.period = dec_period;
    state_d.halt = dec_halt;
    state_d.base = dec_base;
    state_d.rsvd_code = dec_rsvd;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
      state_q.enable <= UDT_ENABLE_RESET;
      state_q.timing <= UDT_TIMING_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign cfg_rdata = state_q.rdata;
  assign cfg_rvalid = state_q.rvalid;
  assign udma_enable = state_q.udma_en;
  assign write_strobe_period = state_q.period;
  assign ready_to_halt_time = state_q.halt;
  assign base_clock_mode = state_q.base;
  assign reserved_code = state_q.rsvd_code;

endmodule

// >>> udt_properties.sv
// Port assertions for the Ultra DMA timing configuration block.
`timescale 1ns/10ps
module udt_properties
  import udt_pkg::*;
(
  // Clock, reset and config port.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0] cfg_byte_en,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  // Primary drive 0 selects and per-drive results.
  input wire logic pri_drive0_base_clock_sel,
  input wire logic pri_drive0_fast_clock_sel,
  input wire logic [UDT_DRIVES-1:0] udma_enable,
  input wire udt_period_t [UDT_DRIVES-1:0] write_strobe_period,
  input wire udt_halt_t [UDT_DRIVES-1:0] ready_to_halt_time,
  input wire logic [UDT_DRIVES-1:0][1:0] base_clock_mode
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_en_wr;
    cfg_wr && cfg_addr[7:2] == 6'h12 && cfg_byte_en[0];
  endsequence
  sequence s_bad_rd;
    cfg_rd && cfg_addr[7:2] != 6'h12;
  endsequence
  a_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("no read answer");
  a_valid_pulse: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray answer");
  a_unmapped_zero: assert property (s_bad_rd |=> cfg_rdata == 32'h0) else $error("unmapped data");
  a_rsvd_read_zero: assert property (cfg_rvalid |-> (cfg_rdata & 32'hCCCC_FFF0) == 32'h0)
    else $error("reserved bits set");
  a_enable_follow: assert property (s_en_wr |=> ##1 udma_enable == $past(cfg_wdata[3:0], 2))
    else $error("enable mismatch");
  a_fast_timing: assert property (pri_drive0_fast_clock_sel |=> base_clock_mode[0] == 2'h2
    && write_strobe_period[0] == 3'h3 && ready_to_halt_time[0] == 5'h10) else $error("fast timing");
  a_mid_table: assert property (!pri_drive0_fast_clock_sel && pri_drive0_base_clock_sel |=>
    base_clock_mode[0] == 2'h1 && ready_to_halt_time[0] == 5'h08 && write_strobe_period[0] inside {3'h2, 3'h3})
    else $error("66 MHz timing");
  a_slow_pair: assert property (!pri_drive0_fast_clock_sel && !pri_drive0_base_clock_sel |=>
    base_clock_mode[0] == 2'h0 && ready_to_halt_time[0] == {2'h0, write_strobe_period[0]} + 5'h02
    && write_strobe_period[0] inside {3'h2, 3'h3, 3'h4}) else $error("33 MHz timing");
endmodule
bind udt_timing_config udt_properties u_props (.sys_clk(sys_clk), .rst(rst), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_byte_en(cfg_byte_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .pri_drive0_base_clock_sel(pri_drive0_base_clock_sel),
  .pri_drive0_fast_clock_sel(pri_drive0_fast_clock_sel), .udma_enable(udma_enable),
  .write_strobe_period(write_strobe_period), .ready_to_halt_time(ready_to_halt_time),
  .base_clock_mode(base_clock_mode));

// >>> udt_drive_model.sv
// Far-side drives, each reporting the Ultra DMA base clock it runs at.
`timescale 1ns/10ps
module udt_drive_model (
  // Two bits a drive: bit 0 asks 66 MHz, bit 1 asks 133 MHz.
  input wire logic [7:0] drive_mode,
  // Select lines towards the controller.
  output logic [3:0] base_sel,
  output logic [3:0] fast_sel
);
  // Mode 3 raises both lines, so the override is exercised.
  for (genvar i = 0; i < 4; i++) begin : g_drv
    assign base_sel[i] = drive_mode[2*i];
    assign fast_sel[i] = drive_mode[2*i+1];
  end
endmodule

// >>> udt_timing_config_bench.sv
// Self-checking bench for the Ultra DMA timing configuration block.
`timescale 1ns/10ps
module udt_timing_config_bench;
  import udt_pkg::*;
  logic sys_clk, rst, cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] cfg_addr, drive_mode, en_m;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic [3:0] cfg_byte_en, be, udma_enable, base_sel, fast_sel, reserved_code;
  udt_period_t [UDT_DRIVES-1:0] write_strobe_period;
  udt_halt_t [UDT_DRIVES-1:0] ready_to_halt_time;
  logic [UDT_DRIVES-1:0][1:0] base_clock_mode;
  logic [15:0] tim_m;
  logic [31:0] exp_q[$];
  int n_mismatch = 0, checks = 0, seed = 97073;
  udt_timing_config u_udt_timing_config (.sys_clk(sys_clk), .rst(rst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_byte_en(cfg_byte_en), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .pri_drive0_base_clock_sel(base_sel[0]), .pri_drive1_base_clock_sel(base_sel[1]),
    .sec_drive0_base_clock_sel(base_sel[2]), .sec_drive1_base_clock_sel(base_sel[3]),
    .pri_drive0_fast_clock_sel(fast_sel[0]), .pri_drive1_fast_clock_sel(fast_sel[1]),
    .sec_drive0_fast_clock_sel(fast_sel[2]), .sec_drive1_fast_clock_sel(fast_sel[3]),
    .udma_enable(udma_enable), .write_strobe_period(write_strobe_period),
    .ready_to_halt_time(ready_to_halt_time), .base_clock_mode(base_clock_mode), .reserved_code(reserved_code));
  udt_drive_model u_udt_drive_model (.drive_mode(drive_mode), .base_sel(base_sel), .fast_sel(fast_sel));
  task automatic fail(input string msg);
    n_mismatch++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) fail(what);
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] we);
    @(negedge sys_clk);
    {cfg_addr, cfg_wdata, cfg_byte_en, cfg_rd, cfg_wr} = {a, wd, we, 2'b01};
    if (a[7:2] == 6'h12 && we[0]) en_m = wd[7:0] & 8'h0F;
    if (a[7:2] == 6'h12 && we[2]) tim_m[7:0] = wd[23:16] & 8'h33;
    if (a[7:2] == 6'h12 && we[3]) tim_m[15:8] = wd[31:24] & 8'h33;
  endtask
  task automatic cfg_read(input logic [7:0] a);
    @(negedge sys_clk);
    {cfg_addr, cfg_rd, cfg_wr} = {a, 2'b10};
    exp_q.push_back(a[7:2] == 6'h12 ? {tim_m, 8'h00, en_m} : 32'h0);
  endtask
  task automatic idle();
    @(negedge sys_clk);
    {cfg_rd, cfg_wr} = 2'b00;
  endtask
  // Expected timing is rebuilt from the code tables, with the slowest legal pair for reserved codes.
  task automatic check_decode();
    logic [2:0] p;
    logic [4:0] h;
    logic [1:0] m, c;
    logic rc;
    for (int i = 0; i < 4; i++) begin
      c = tim_m[4*i +: 2];
      m = drive_mode[2*i+1] ? 2'h2 : {1'b0, drive_mode[2*i]};
      p = (m == 2'h0 && c != 2'h1 && c != 2'h2) ? 3'h4 : (c == 2'h2 && m != 2'h2) ? 3'h2 : 3'h3;
      h = m == 2'h2 ? 5'h10 : m == 2'h1 ? 5'h08 : {2'h0, p} + 5'h02;
      rc = m == 2'h2 ? c != 2'h1 : m == 2'h1 ? (c == 2'h0 || c == 2'h3) : c == 2'h3;
      cmp({write_strobe_period[i], ready_to_halt_time[i], base_clock_mode[i], reserved_code[i], udma_enable[i]},
        {p, h, m, rc, en_m[i]}, "drive decode");
    end
  endtask
  task automatic drain();
    for (int i = 0; i < 8 && exp_q.size() > 0; i++) @(negedge sys_clk);
    if (exp_q.size() > 0) fail("read answer missing");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge sys_clk) begin
    if (cfg_rvalid === 1'b1 && exp_q.size() == 0) fail("stray read answer");
    else if (cfg_rvalid === 1'b1) cmp(cfg_rdata, exp_q.pop_front(), "read data");
  end
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail("run timeout");
    end_of_test();
  end
  initial begin
    {rst, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cfg_byte_en} = {3'b100, 8'h00, 32'h0, 4'h0};
    {drive_mode, en_m, tim_m} = {8'h00, 8'h00, 16'h0000};
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    cfg_read(8'h48);
    idle();
    check_decode();
    $display("test reset done");
    // Reserved bits must not stick; the neighbouring dword is not mapped.
    cfg_write(8'h48, 32'hFFFF_FFFF, 4'hF);
    cfg_write(8'h4C, 32'h0, 4'hF);
    cfg_read(8'h4A);
    cfg_read(8'h4C);
    idle();
    drain();
    $display("test reserved done");
    // First every code under every mode, then random lanes and modes.
    for (int k = 0; k < 40; k++) begin
      d = $random(seed);
      be = k < 16 ? 4'hF : 4'($random(seed));
      if (k < 16) d[31:16] = {8{k[1:0]}};
      cfg_write(8'h48, d, be);
      cfg_read(8'h48);
      idle();
      drive_mode = k < 16 ? {4{k[3:2]}} : 8'($random(seed));
      repeat (2) @(negedge sys_clk);
      check_decode();
    end
    drain();
    $display("test sweep done");
    // A second reset in mid-run must bring back the power-up contents.
    @(negedge sys_clk) rst = 1'b1;
    {en_m, tim_m} = {8'h00, 16'h0000};
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    cfg_read(8'h48);
    idle();
    check_decode();
    drain();
    $display("test mid reset done");
    end_of_test();
  end
endmodule
